// ==== rtl/psdc_ms_timer.sv ====
`timescale 1ns/1ps
module psdc_ms_timer
  import psdc_pkg::*;
#(
  parameter int CYCLES_PER_STEP = PSDC_CYCLES_PER_STEP
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic abort,
  input wire logic [PSDC_DELAY_W-1:0] delay_steps,
  output logic busy,
  output logic done
);

  logic [31:0] tick_q;
  logic [31:0] tick_d;
  logic [PSDC_DELAY_W-1:0] left_q;
  logic [PSDC_DELAY_W-1:0] left_d;
  logic busy_d;
  logic done_d;
  logic tick_end;

  assign tick_end = (tick_q == 32'(CYCLES_PER_STEP - 1));

  // A delay of zero finishes on the edge after the start, so done is always one pulse.
  always_comb begin
    tick_d = tick_q;
    left_d = left_q;
    busy_d = busy;
    done_d = 1'b0;
    if (abort) begin
      busy_d = 1'b0;
      tick_d = '0;
    end else if (start) begin
      tick_d = '0;
      left_d = delay_steps;
      busy_d = (delay_steps != PSDC_DELAY_RST);
      done_d = (delay_steps == PSDC_DELAY_RST);
    end else if (busy) begin
      if (tick_end) begin
        tick_d = '0;
        left_d = left_q - 7'h01;
        if (left_q == 7'h01) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end else begin
        tick_d = tick_q + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= '0;
      left_q <= PSDC_DELAY_RST;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      tick_q <= tick_d;
      left_q <= left_d;
      busy <= busy_d;
      done <= done_d;
    end
  end

endmodule

// ==== rtl/psdc_pkg.sv ====
package psdc_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] PSDC_OFF_DELAY_ADDR = 8'h00;
  localparam logic [7:0] PSDC_ON_DELAY_ADDR = 8'h04;
  localparam logic [7:0] PSDC_CTRL_ADDR = 8'h08;
  localparam logic [7:0] PSDC_STATUS_ADDR = 8'h0c;
  localparam int PSDC_ADDR_W = 8;
  localparam int PSDC_DATA_W = 32;

  // Delay fields: seven bits of milliseconds, top bit of the byte unused.
  localparam int PSDC_DELAY_W = 7;
  localparam logic [6:0] PSDC_DELAY_RST = 7'h00;
  localparam int PSDC_SEL_W = 4;

  // Control register fields.
  localparam int PSDC_CTRL_PG_MODE_BIT = 0;
  localparam logic PSDC_CTRL_PG_MODE_RST = 1'b0;

  // Status register field positions.
  localparam int PSDC_ST_PIN3_BIT = 0;
  localparam int PSDC_ST_PIN4_BIT = 1;
  localparam int PSDC_ST_OFF_BUSY_BIT = 2;
  localparam int PSDC_ST_ON_BUSY_BIT = 3;
  localparam int PSDC_ST_PG_LSB = 4;
  localparam int PSDC_ST_SEL_PG_BIT = 14;
  localparam int PSDC_ST_STATE_LSB = 16;

  // Power-good sources: six step-down rails, three linear rails, termination reference.
  localparam int PSDC_NUM_RAILS = 10;
  localparam logic [3:0] PSDC_SEL_STEP_DOWN_ONE = 4'h0;
  localparam logic [3:0] PSDC_SEL_STEP_DOWN_TWO = 4'h1;
  localparam logic [3:0] PSDC_SEL_TERM_REF = 4'h9;
  localparam logic [3:0] PSDC_SEL_ALL_AND = 4'ha;

  // Timing: one delay step is one millisecond at a 25 ns clock.
  localparam int PSDC_STEP_NS = 1000000;
  localparam int PSDC_CLK_PERIOD_NS = 25;
  localparam int PSDC_CYCLES_PER_STEP = PSDC_STEP_NS / PSDC_CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    PSDC_ST_OFF = 4'h1,
    PSDC_ST_ON_WAIT = 4'h2,
    PSDC_ST_ON = 4'h4,
    PSDC_ST_OFF_WAIT = 4'h8
  } psdc_state_t;

endpackage

// ==== rtl/psdc_top.sv ====
// Functional notes
// - Pin three off delay: 7 bits, milliseconds.
// - Pin four on delay: 7 bits, milliseconds.
// - Power-good mode: low nibble selects rail.
// - Code zero, one: step-down rails one, two.
// - Further codes: rails, reference, then AND-all.
`timescale 1ns/1ps
module psdc_top
  import psdc_pkg::*;
#(
  parameter int CYCLES_PER_STEP = PSDC_CYCLES_PER_STEP,
  parameter int NUM_RAILS = PSDC_NUM_RAILS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PSDC_ADDR_W-1:0] paddr,
  input wire logic [PSDC_DATA_W-1:0] pwdata,
  output logic [PSDC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic seq_on_start,
  input wire logic seq_off_start,
  input wire logic [NUM_RAILS-1:0] power_good_flag,
  output logic multipurpose_pin_three,
  output logic multipurpose_pin_four
);

  // Rail power-good levels come from analog comparators outside this clock.
  logic [NUM_RAILS-1:0] pg_meta_q;
  logic [NUM_RAILS-1:0] pg_sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_meta_q <= '0;
      pg_sync_q <= '0;
    end else begin
      pg_meta_q <= power_good_flag;
      pg_sync_q <= pg_meta_q;
    end
  end

  // Selector decode, shared by the pin drive and the status view.
  function automatic logic pg_select(input logic [PSDC_SEL_W-1:0] sel,
                                     input logic [NUM_RAILS-1:0] pg);
    logic res;
    res = 1'b0;
    if (sel == PSDC_SEL_ALL_AND) begin
      res = &pg;
    end else if (sel <= PSDC_SEL_TERM_REF) begin
      res = pg[sel];
    end
    return res;
  endfunction

  // APB registers.
  logic [PSDC_DELAY_W-1:0] off_delay_q;
  logic [PSDC_DELAY_W-1:0] on_delay_q;
  logic pg_mode_q;
  logic pready_q;
  logic pslverr_q;
  logic [PSDC_DATA_W-1:0] prdata_q;
  logic [PSDC_DATA_W-1:0] rdata_d;

  wire access_wait = psel && penable && !pready_q;
  wire access_done = psel && penable && pready_q;
  wire wr_done = access_done && pwrite;
  wire hit_off = (paddr == PSDC_OFF_DELAY_ADDR);
  wire hit_on = (paddr == PSDC_ON_DELAY_ADDR);
  wire hit_ctrl = (paddr == PSDC_CTRL_ADDR);
  wire hit_status = (paddr == PSDC_STATUS_ADDR);
  wire addr_ok = hit_off || hit_on || hit_ctrl || hit_status;
  // Status is read-only; a write to it is refused like an unmapped address.
  wire addr_err = !addr_ok || (pwrite && hit_status);

  // Sequencer tracking state and timers.
  psdc_state_t state_q;
  psdc_state_t state_d;
  logic off_busy;
  logic off_done;
  logic on_busy;
  logic on_done;
  logic on_start_q;
  logic on_start_d;
  logic off_start_q;
  logic off_start_d;

  // Pin three counts its delay from the start of power-off.
  psdc_ms_timer #(
    .CYCLES_PER_STEP(CYCLES_PER_STEP)
  ) u_off_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(off_start_q),
    .abort(on_start_q),
    .delay_steps(off_delay_q),
    .busy(off_busy),
    .done(off_done)
  );

  // Pin four counts its delay from the start of power-on.
  psdc_ms_timer #(
    .CYCLES_PER_STEP(CYCLES_PER_STEP)
  ) u_on_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(on_start_q),
    .abort(off_start_q),
    .delay_steps(on_delay_q),
    .busy(on_busy),
    .done(on_done)
  );

  // Power-on wins when both starts arrive together, so a rail restart is never lost.
  assign on_start_d = seq_on_start;
  assign off_start_d = seq_off_start && !seq_on_start;

  always_comb begin
    state_d = state_q;
    if (on_start_q) begin
      state_d = PSDC_ST_ON_WAIT;
    end else if (off_start_q) begin
      state_d = PSDC_ST_OFF_WAIT;
    end else begin
      case (state_q)
        PSDC_ST_OFF: begin
          state_d = PSDC_ST_OFF;
        end
        PSDC_ST_ON_WAIT: begin
          if (on_done) begin
            state_d = PSDC_ST_ON;
          end
        end
        PSDC_ST_ON: begin
          state_d = PSDC_ST_ON;
        end
        PSDC_ST_OFF_WAIT: begin
          if (off_done) begin
            state_d = PSDC_ST_OFF;
          end
        end
        default: begin
          state_d = PSDC_ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PSDC_ST_OFF;
      on_start_q <= 1'b0;
      off_start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      on_start_q <= on_start_d;
      off_start_q <= off_start_d;
    end
  end

  // Pin drive decisions.
  logic pin3_d;
  logic pin4_d;
  logic sel_pg;

  assign sel_pg = pg_select(on_delay_q[PSDC_SEL_W-1:0], pg_sync_q);

  assign pin3_d = (state_d != PSDC_ST_OFF);

  assign pin4_d = pg_mode_q ? sel_pg : (state_d == PSDC_ST_ON);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multipurpose_pin_three <= 1'b0;
      multipurpose_pin_four <= 1'b0;
    end else begin
      multipurpose_pin_three <= pin3_d;
      multipurpose_pin_four <= pin4_d;
    end
  end

  // Register writes take effect on the edge that completes the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_delay_q <= PSDC_DELAY_RST;
      on_delay_q <= PSDC_DELAY_RST;
      pg_mode_q <= PSDC_CTRL_PG_MODE_RST;
    end else if (wr_done && !pslverr_q) begin
      if (hit_off) begin
        off_delay_q <= pwdata[PSDC_DELAY_W-1:0];
      end
      if (hit_on) begin
        on_delay_q <= pwdata[PSDC_DELAY_W-1:0];
      end
      if (hit_ctrl) begin
        pg_mode_q <= pwdata[PSDC_CTRL_PG_MODE_BIT];
      end
    end
  end

  // Read mux; bits above each field read as zero.
  always_comb begin
    rdata_d = '0;
    if (hit_off) begin
      rdata_d[PSDC_DELAY_W-1:0] = off_delay_q;
    end else if (hit_on) begin
      rdata_d[PSDC_DELAY_W-1:0] = on_delay_q;
    end else if (hit_ctrl) begin
      rdata_d[PSDC_CTRL_PG_MODE_BIT] = pg_mode_q;
    end else if (hit_status) begin
      rdata_d[PSDC_ST_PIN3_BIT] = multipurpose_pin_three;
      rdata_d[PSDC_ST_PIN4_BIT] = multipurpose_pin_four;
      rdata_d[PSDC_ST_OFF_BUSY_BIT] = off_busy;
      rdata_d[PSDC_ST_ON_BUSY_BIT] = on_busy;
      rdata_d[PSDC_ST_PG_LSB +: NUM_RAILS] = pg_sync_q;
      rdata_d[PSDC_ST_SEL_PG_BIT] = sel_pg;
      rdata_d[PSDC_ST_STATE_LSB +: 4] = state_q;
    end
  end

  // One wait state per access keeps every bus output straight from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (access_wait) begin
      pready_q <= 1'b1;
      pslverr_q <= addr_err;
      prdata_q <= (pwrite || addr_err) ? '0 : rdata_d;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

endmodule

// ==== verif/psdc_top_assertions.sv ====
`timescale 1ns/1ps
module psdc_top_assertions
  import psdc_pkg::*;
#(
  parameter int CYCLES_PER_STEP = 4,
  parameter int NUM_RAILS = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic seq_on_start,
  input wire logic seq_off_start,
  input wire logic [NUM_RAILS-1:0] power_good_flag,
  input wire logic multipurpose_pin_three,
  input wire logic multipurpose_pin_four
);
  // Longest delay plus the start and pin register stages.
  localparam int DMAX = 127 * CYCLES_PER_STEP + 8;
  logic mode_q;
  logic [3:0] sel_q;
  wire p3 = multipurpose_pin_three;
  wire p4 = multipurpose_pin_four;
  wire wr_ok = psel && penable && pready && pwrite && !pslverr;
  wire pg_exp = sel_q < 4'ha ? power_good_flag[sel_q] : sel_q == 4'ha && &power_good_flag;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b0;
      sel_q <= 4'h0;
    end else if (wr_ok && paddr == 8'h08) begin
      mode_q <= pwdata[0];
    end else if (wr_ok && paddr == 8'h04) begin
      sel_q <= pwdata[3:0];
    end
  end
  // Eight quiet cycles cover the two-flop sync and the pin register.
  sequence calm;
    (mode_q && $stable(power_good_flag) && !wr_ok)[*8];
  endsequence
  a_pg_rail_pick: assert property (calm |-> p4 == pg_exp)
    else $error("pin four not the selected rail");
  a_pg_low_codes: assert property (calm ##0 sel_q < 4'h2 |-> p4 == power_good_flag[sel_q[0]])
    else $error("low selector codes wrong");
  a_pg_and_all: assert property (calm ##0 sel_q == 4'ha |-> p4 == &power_good_flag)
    else $error("all-rails code wrong");
  a_off_delay_end: assert property (seq_off_start && !seq_on_start |-> ##[1:DMAX] (!p3 || seq_on_start))
    else $error("pin three never dropped");
  a_on_delay_end: assert property (seq_on_start && !mode_q |-> ##[1:DMAX] (p4 || seq_off_start || mode_q))
    else $error("pin four never rose");
  a_unused_bit: assert property (pready && !pwrite && paddr < 8'h08 |-> prdata[31:7] == 25'h0)
    else $error("unused delay bits not zero");
  a_pin_three_up: assert property (seq_on_start |-> ##2 p3)
    else $error("pin three late at power-on");
  a_one_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("access not one wait state");
  c_pg_and: cover property (calm ##0 sel_q == 4'ha);
  c_on_seq: cover property (seq_on_start ##[1:DMAX] p4);
  c_refused: cover property (pready && pslverr);
endmodule

bind psdc_top psdc_top_assertions #(.CYCLES_PER_STEP(CYCLES_PER_STEP), .NUM_RAILS(NUM_RAILS)) u_chk (.*);

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import psdc_pkg::*;
;
  localparam int CPS = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic seq_on_start = 1'b0;
  logic seq_off_start = 1'b0;
  logic [9:0] power_good_flag = 10'h000;
  logic multipurpose_pin_three;
  logic multipurpose_pin_four;
  logic [31:0] q;
  logic e;
  logic x;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  int dl[3] = '{0, 5, 127};

  psdc_top #(.CYCLES_PER_STEP(CPS)) u_psdc_top (.*);

  initial forever #12.5 pclk = ~pclk;

  task summarize;
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] s, input logic [31:0] w);
    checks++;
    if (s !== w) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, w, s);
    end
  endtask

  // The idle cycle at the end keeps two calls from driving psel in one step.
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task go(input logic on);
    if (on) seq_on_start <= 1'b1;
    else seq_off_start <= 1'b1;
    @(posedge pclk);
    seq_on_start <= 1'b0;
    seq_off_start <= 1'b0;
    n = 0;
    while ((on ? multipurpose_pin_four : multipurpose_pin_three) !== on && n < 700) begin
      @(posedge pclk);
      n++;
    end
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    // The run needs under ten thousand cycles.
    if (cyc == 30000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 4; a++) begin
      xf(1'b0, 8'(a * 4), 32'h0);
      chk("reset_val", q, a == 3 ? 32'h10000 : 32'h0);
    end
    xf(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", e, 1'b1);
    chk("unmapped_data", q, 32'h0);
    xf(1'b1, 8'h0c, 32'h1);
    chk("status_ro", e, 1'b1);
    foreach (dl[i]) begin
      for (int c = 1; c >= 0; c--) begin
        xf(1'b1, 8'(c * 4), 32'hffffff80 | dl[i]);
        xf(1'b0, 8'(c * 4), 32'h0);
        chk("delay_reg", q, dl[i]);
        chk("delay_reg_err", e, 1'b0);
        go(c == 1);
        chk("delay_time", n >= CPS * dl[i] + 2 && n <= CPS * dl[i] + 7, 1'b1);
      end
    end
    xf(1'b1, 8'h08, 32'h1);
    for (int c = 0; c < 16; c++) begin
      xf(1'b1, 8'h04, c);
      for (int k = 0; k < 2; k++) begin
        power_good_flag <= k ? ~(10'h1 << c) : 10'h1 << c;
        repeat (8) @(posedge pclk);
        x = c < 10 ? power_good_flag[c] : c == 10 && &power_good_flag;
        xf(1'b0, 8'h0c, 32'h0);
        chk("pg_pin", multipurpose_pin_four, x);
        chk("pg_status", q[14:4], {x, power_good_flag});
      end
    end
    summarize();
  end
endmodule
